// ---- sico_pkg.sv ----
// sico_pkg: register map, field layout, reset values and lookup helpers for the servo I/O conditioning block
package sico_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_POLES = 5'h04;
  localparam logic [4:0] OFF_LINE_SEL = 5'h08;
  localparam logic [4:0] OFF_PPR = 5'h0c;
  localparam logic [4:0] OFF_ZOFFSET = 5'h10;
  localparam logic [4:0] OFF_MON_SEL = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;

  // control register fields
  localparam int CTRL_ENABLE_INV = 0;
  localparam int CTRL_CW_INV = 1;
  localparam int CTRL_CCW_INV = 2;
  localparam int CTRL_MULTI_INV = 3;
  localparam int CTRL_CCW_INH_EN = 4;
  localparam int CTRL_CW_INH_EN = 5;
  localparam int CTRL_W = 6;

  // monitor select fields
  localparam int MON1_LSB = 0;
  localparam int MON2_LSB = 8;
  localparam int MON_SEL_W = 3;

  // status register fields
  localparam int STAT_COND_LSB = 0;
  localparam int STAT_COMM_EN = 4;
  localparam int STAT_LINES_LSB = 16;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [4:0] POLES_RST = 5'h00;
  localparam logic [3:0] LINE_SEL_RST = 4'h0;
  localparam logic [15:0] PPR_RST = 16'h8000;
  localparam logic [15:0] ZOFFSET_RST = 16'h0000;
  localparam logic [MON_SEL_W-1:0] MON_SEL_RST = 3'h0;

  // line count selection
  localparam logic [3:0] SEL_PROGRAMMABLE = 4'he;
  localparam logic [3:0] SWITCH_USER = 4'h0;

  // monitor DAC
  localparam int DAC_W = 12;
  localparam logic [11:0] DAC_BIAS = 12'h800;

  typedef enum logic [MON_SEL_W-1:0] {
    SICO_MON_VEL_ERR,
    SICO_MON_POS_BIG,
    SICO_MON_CURRENT,
    SICO_MON_VEL_FB,
    SICO_MON_CMD_IN,
    SICO_MON_CMD_OUT,
    SICO_MON_POS_LITTLE,
    SICO_MON_ZERO
  } sico_mon_e;

  // fixed line count for a selector code; the programmable code returns its default
  function automatic logic [15:0] sico_line_table(input logic [3:0] code);
    case (code)
      4'h0: return 16'd500;
      4'h1: return 16'd512;
      4'h2: return 16'd1000;
      4'h3: return 16'd1024;
      4'h4: return 16'd2000;
      4'h5: return 16'd2048;
      4'h6: return 16'd4096;
      4'h7: return 16'd5000;
      4'h8: return 16'd8192;
      4'h9: return 16'd10000;
      4'ha: return 16'd125;
      4'hb: return 16'd128;
      4'hc: return 16'd16384;
      4'hd: return 16'd20000;
      4'he: return PPR_RST;
      default: return 16'd2500;
    endcase
  endfunction : sico_line_table

endpackage : sico_pkg

// ---- sico_enc_emu.sv ----
// sico_enc_emu: emulated quadrature encoder outputs with shiftable marker
module sico_enc_emu import sico_pkg::*; #(
  parameter int POS_W = 16,
  parameter int LINE_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // position and setup
  input wire logic [POS_W-1:0] pos,
  input wire logic [LINE_W-1:0] lines,
  input wire logic [POS_W-1:0] offset,
  input wire logic suppress,
  // emulated encoder
  output logic chan_a,
  output logic chan_b,
  output logic marker
);

  localparam int Q_W = LINE_W + 2;
  localparam int P_W = POS_W + Q_W;
  localparam logic [POS_W-1:0] QUARTER_REV = POS_W'(1) << (POS_W - 2);

  if (POS_W < 4 || LINE_W < 1) begin : g_bad
    $error("sico_enc_emu: widths too small");
  end

  // quadrature count within one revolution: pos * 4 * lines / 2^POS_W
  function automatic logic [Q_W-1:0] quad_index(input logic [POS_W-1:0] p, input logic [LINE_W-1:0] l);
    logic [P_W-1:0] prod;
    prod = {{Q_W{1'b0}}, p} * {{POS_W{1'b0}}, l, 2'b00};
    return prod[P_W-1:POS_W];
  endfunction : quad_index

  logic [Q_W-1:0] qcount_reg;
  logic [Q_W-1:0] qcount_next;
  logic [Q_W-1:0] zcount;
  logic [POS_W-1:0] zpos;
  logic marker_next;

  assign qcount_next = quad_index(pos, lines);
  assign zpos = pos - offset;
  assign zcount = quad_index(zpos, lines);
  assign marker_next = !suppress && (lines != '0) && (zcount == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qcount_reg <= '0;
      chan_a <= 1'b0;
      chan_b <= 1'b0;
      marker <= 1'b0;
    end else begin
      qcount_reg <= qcount_next;
      chan_a <= qcount_next[1];
      chan_b <= qcount_next[1] ^ qcount_next[0];
      marker <= marker_next;
    end
  end

  quarter_rev_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pos == QUARTER_REV) |=> (qcount_reg == Q_W'($past(lines))))
    else $error("quarter revolution does not give one line count of quadrature counts");

  marker_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    suppress |=> !marker)
    else $error("marker pulse not suppressed");

  marker_pos_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pos == offset && lines != '0 && !suppress) |=> marker)
    else $error("marker missing at offset position");

endmodule : sico_enc_emu

// ---- sico_top.sv ----
// sico_top: servo digital input conditioning, inhibit clamp, pole setting, encoder emulation and monitor DACs
// Summary of operation
// - enable input is inverted when its invert bit is set, else passed.
// - clockwise-inhibit input is inverted when its invert bit is set, else passed.
// - counter-clockwise-inhibit input is inverted when its invert bit is set, else passed.
// - multi-function input is inverted when its invert bit is set, else passed.
// - each monitor selector routes one chosen internal variable to its DAC.
// - monitor DAC values wrap around instead of saturating.
// - pole setting is a 5-bit N giving 2N poles, even up to 62.
// - pole setting zero switches electronic commutation off.
// - line count selector applies only at switch position 0; others fixed.
// - selector codes other than 14 at switch 0 map to the fixed line count table.
// - quadrature output gives four counts per line per revolution.
// - programmable line count used only at switch 0 and selector code 14.
// - programmable count zero with programmable selected suppresses the marker.
// - marker decoding uses position feedback minus the marker offset.
// - active enabled counter-clockwise inhibit clamps the command to zero or positive.
// - active enabled clockwise inhibit clamps the command to zero or negative.
// - both inhibits enabled and active force the command to zero.
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
module sico_top import sico_pkg::*; #(
  parameter int CMD_W = 16,
  parameter int POS_W = 16
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // hardware digital inputs
  input wire logic ENABLE_INPUT,
  input wire logic CW_INHIBIT_INPUT,
  input wire logic CCW_INHIBIT_INPUT,
  input wire logic MULTI_FUNCTION_INPUT,
  input wire logic [3:0] SETUP_ROTARY_SWITCH,
  // servo loop variables
  input wire logic signed [CMD_W-1:0] CMD_IN,
  input wire logic [POS_W-1:0] POSITION_FEEDBACK,
  input wire logic signed [15:0] VEL_ERR,
  input wire logic signed [15:0] VEL_FB,
  input wire logic signed [15:0] CURRENT_FB,
  // conditioned inputs and command
  output logic ENABLE_OUT,
  output logic CW_INHIBIT_OUT,
  output logic CCW_INHIBIT_OUT,
  output logic MULTI_FUNCTION_OUT,
  output logic signed [CMD_W-1:0] CMD_OUT,
  // commutation
  output logic COMMUTATION_ENABLE,
  output logic [5:0] MOTOR_POLES,
  // emulated encoder
  output logic ENC_A,
  output logic ENC_B,
  output logic ENC_Z,
  // monitor DACs
  output logic [DAC_W-1:0] MONITOR1_OUTPUT,
  output logic [DAC_W-1:0] MONITOR2_OUTPUT
);

  if (CMD_W < 2 || POS_W != 16) begin : g_bad
    $error("sico_top: CMD_W must be at least 2 and POS_W must be 16");
  end

  // ---------------- bus slave ----------------
  logic ack_reg;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] rd_word;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic [4:0] poles_reg;
  logic [4:0] poles_next;
  logic [3:0] sel_reg;
  logic [3:0] sel_next;
  logic [15:0] ppr_reg;
  logic [15:0] ppr_next;
  logic [15:0] zoff_reg;
  logic [15:0] zoff_next;
  logic [MON_SEL_W-1:0] mon1_sel_reg;
  logic [MON_SEL_W-1:0] mon1_sel_next;
  logic [MON_SEL_W-1:0] mon2_sel_reg;
  logic [MON_SEL_W-1:0] mon2_sel_next;

  // byte-lane merge of a write into the current register word
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_be

  // one wait cycle on every access; read data is captured on the first edge so it stands while waitrequest is low
  assign req = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = req && !ack_reg;
  assign wr_go = AVS_WRITE && ack_reg;
  assign rd_go = AVS_READ && !ack_reg;
  assign AVS_READDATA = rdata_reg;

  logic sel_ctrl;
  logic sel_poles;
  logic sel_line;
  logic sel_ppr;
  logic sel_zoff;
  logic sel_mon;
  logic sel_stat;
  assign sel_ctrl = AVS_ADDRESS == OFF_CTRL;
  assign sel_poles = AVS_ADDRESS == OFF_POLES;
  assign sel_line = AVS_ADDRESS == OFF_LINE_SEL;
  assign sel_ppr = AVS_ADDRESS == OFF_PPR;
  assign sel_zoff = AVS_ADDRESS == OFF_ZOFFSET;
  assign sel_mon = AVS_ADDRESS == OFF_MON_SEL;
  assign sel_stat = AVS_ADDRESS == OFF_STATUS;

  logic [31:0] ctrl_word;
  logic [31:0] poles_word;
  logic [31:0] line_word;
  logic [31:0] ppr_word;
  logic [31:0] zoff_word;
  logic [31:0] mon_word;
  logic [31:0] stat_word;
  logic [31:0] ctrl_wr;
  logic [31:0] poles_wr;
  logic [31:0] line_wr;
  logic [31:0] ppr_wr;
  logic [31:0] zoff_wr;
  logic [31:0] mon_wr;

  assign ctrl_word = {{(32-CTRL_W){1'b0}}, ctrl_reg};
  assign poles_word = {27'h0000000, poles_reg};
  assign line_word = {28'h0000000, sel_reg};
  assign ppr_word = {16'h0000, ppr_reg};
  assign zoff_word = {16'h0000, zoff_reg};
  assign mon_word = {21'h000000, mon2_sel_reg, 5'h00, mon1_sel_reg};

  assign ctrl_wr = merge_be(ctrl_word, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign poles_wr = merge_be(poles_word, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign line_wr = merge_be(line_word, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign ppr_wr = merge_be(ppr_word, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign zoff_wr = merge_be(zoff_word, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign mon_wr = merge_be(mon_word, AVS_WRITEDATA, AVS_BYTEENABLE);

  assign ctrl_next = (wr_go && sel_ctrl) ? ctrl_wr[CTRL_W-1:0] : ctrl_reg;
  assign poles_next = (wr_go && sel_poles) ? poles_wr[4:0] : poles_reg;
  assign sel_next = (wr_go && sel_line) ? line_wr[3:0] : sel_reg;
  assign ppr_next = (wr_go && sel_ppr) ? ppr_wr[15:0] : ppr_reg;
  assign zoff_next = (wr_go && sel_zoff) ? zoff_wr[15:0] : zoff_reg;
  assign mon1_sel_next = (wr_go && sel_mon) ? mon_wr[MON1_LSB +: MON_SEL_W] : mon1_sel_reg;
  assign mon2_sel_next = (wr_go && sel_mon) ? mon_wr[MON2_LSB +: MON_SEL_W] : mon2_sel_reg;

  // unmapped addresses read as zero and ignore writes
  assign rd_word = sel_ctrl ? ctrl_word :
                   sel_poles ? poles_word :
                   sel_line ? line_word :
                   sel_ppr ? ppr_word :
                   sel_zoff ? zoff_word :
                   sel_mon ? mon_word :
                   sel_stat ? stat_word : 32'h00000000;
  assign rdata_next = rd_go ? rd_word : rdata_reg;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= req && !ack_reg;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_reg <= CTRL_RST;
      poles_reg <= POLES_RST;
      sel_reg <= LINE_SEL_RST;
      ppr_reg <= PPR_RST;
      zoff_reg <= ZOFFSET_RST;
      mon1_sel_reg <= MON_SEL_RST;
      mon2_sel_reg <= MON_SEL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      poles_reg <= poles_next;
      sel_reg <= sel_next;
      ppr_reg <= ppr_next;
      zoff_reg <= zoff_next;
      mon1_sel_reg <= mon1_sel_next;
      mon2_sel_reg <= mon2_sel_next;
    end
  end

  // ---------------- pin conditioning ----------------
  // bits 3:0 digital inputs, bits 7:4 rotary switch
  logic [7:0] pins;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] sync3_reg;
  logic [7:0] filt_reg;
  logic [7:0] filt_next;
  logic [3:0] invert;
  logic [3:0] cond_reg;
  logic [3:0] cond_next;
  logic [3:0] switch_pos;

  assign pins = {SETUP_ROTARY_SWITCH, MULTI_FUNCTION_INPUT, CCW_INHIBIT_INPUT, CW_INHIBIT_INPUT, ENABLE_INPUT};
  // a bit follows once stages two and three agree, else holds
  assign filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
  assign invert = {ctrl_reg[CTRL_MULTI_INV], ctrl_reg[CTRL_CCW_INV], ctrl_reg[CTRL_CW_INV], ctrl_reg[CTRL_ENABLE_INV]};
  assign cond_next = filt_reg[3:0] ^ invert;
  assign switch_pos = filt_reg[7:4];

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
      filt_reg <= 8'h00;
      cond_reg <= 4'h0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
      cond_reg <= cond_next;
    end
  end

  assign ENABLE_OUT = cond_reg[0];
  assign CW_INHIBIT_OUT = cond_reg[1];
  assign CCW_INHIBIT_OUT = cond_reg[2];
  assign MULTI_FUNCTION_OUT = cond_reg[3];

  // ---------------- inhibit clamp ----------------
  logic cw_limit;
  logic ccw_limit;
  logic signed [CMD_W-1:0] cmd_reg;
  logic signed [CMD_W-1:0] cmd_next;

  function automatic logic signed [CMD_W-1:0] clamp_cmd(input logic signed [CMD_W-1:0] c, input logic ccw_lim,
                                                        input logic cw_lim);
    if (ccw_lim && cw_lim) begin
      return '0;
    end else if (ccw_lim && c < 0) begin
      return '0;
    end else if (cw_lim && c > 0) begin
      return '0;
    end
    return c;
  endfunction : clamp_cmd

  assign ccw_limit = ctrl_reg[CTRL_CCW_INH_EN] && cond_reg[2];
  assign cw_limit = ctrl_reg[CTRL_CW_INH_EN] && cond_reg[1];
  assign cmd_next = clamp_cmd(CMD_IN, ccw_limit, cw_limit);

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  assign CMD_OUT = cmd_reg;

  // ---------------- commutation ----------------
  assign COMMUTATION_ENABLE = poles_reg != 5'h00;
  assign MOTOR_POLES = {poles_reg, 1'b0};

  // ---------------- encoder emulation ----------------
  logic [15:0] active_lines;
  logic user_switch;
  logic prog_sel;
  logic marker_suppress;

  assign user_switch = switch_pos == SWITCH_USER;
  assign prog_sel = user_switch && sel_reg == SEL_PROGRAMMABLE;
  // other switch positions index the same fixed table
  assign active_lines = prog_sel ? ppr_reg :
                        user_switch ? sico_line_table(sel_reg) :
                        sico_line_table(switch_pos);
  // the host gates the marker by writing a zero programmable count while code 14 is selected at switch 0
  assign marker_suppress = prog_sel && ppr_reg == 16'h0000;
  assign stat_word = {active_lines, 11'h000, COMMUTATION_ENABLE, cond_reg};

  sico_enc_emu #(
    .POS_W(POS_W),
    .LINE_W(16)
  ) u_enc (
    .clk(MCLK),
    .rst_n(NRST),
    .pos(POSITION_FEEDBACK),
    .lines(active_lines),
    .offset(zoff_reg),
    .suppress(marker_suppress),
    .chan_a(ENC_A),
    .chan_b(ENC_B),
    .marker(ENC_Z)
  );

  // ---------------- monitor DACs ----------------
  logic [DAC_W-1:0] mon1_reg;
  logic [DAC_W-1:0] mon2_reg;
  logic [DAC_W-1:0] mon1_next;
  logic [DAC_W-1:0] mon2_next;
  logic [15:0] cmd_in_ext;
  logic [15:0] cmd_out_ext;
  logic [15:0] mon1_pick;
  logic [15:0] mon2_pick;

  assign cmd_in_ext = 16'(CMD_IN);
  assign cmd_out_ext = 16'(cmd_reg);

  // every source is an argument so the selection re-evaluates whenever any source moves
  function automatic logic [15:0] mon_pick(input logic [MON_SEL_W-1:0] s, input logic [15:0] ve, input logic [15:0] pf,
                                           input logic [15:0] cf, input logic [15:0] vf, input logic [15:0] cin,
                                           input logic [15:0] cout);
    case (sico_mon_e'(s))
      SICO_MON_VEL_ERR: return ve;
      SICO_MON_POS_BIG: return pf;
      SICO_MON_CURRENT: return cf;
      SICO_MON_VEL_FB: return vf;
      SICO_MON_CMD_IN: return cin;
      SICO_MON_CMD_OUT: return cout;
      SICO_MON_POS_LITTLE: return {pf[11:0], 4'h0};
      default: return 16'h0000;
    endcase
  endfunction : mon_pick

  // modular add around mid-scale: overrange wraps to the opposite end
  assign mon1_pick = mon_pick(mon1_sel_reg, VEL_ERR, POSITION_FEEDBACK, CURRENT_FB, VEL_FB, cmd_in_ext, cmd_out_ext);
  assign mon2_pick = mon_pick(mon2_sel_reg, VEL_ERR, POSITION_FEEDBACK, CURRENT_FB, VEL_FB, cmd_in_ext, cmd_out_ext);
  assign mon1_next = mon1_pick[15:4] + DAC_BIAS;
  assign mon2_next = mon2_pick[15:4] + DAC_BIAS;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mon1_reg <= DAC_BIAS;
      mon2_reg <= DAC_BIAS;
    end else begin
      mon1_reg <= mon1_next;
      mon2_reg <= mon2_next;
    end
  end

  assign MONITOR1_OUTPUT = mon1_reg;
  assign MONITOR2_OUTPUT = mon2_reg;

  // ---------------- assertions ----------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence quiet_enable_s;
    $stable({ENABLE_INPUT, ctrl_reg[CTRL_ENABLE_INV]})[*5];
  endsequence
  sequence quiet_cw_s;
    $stable({CW_INHIBIT_INPUT, ctrl_reg[CTRL_CW_INV]})[*5];
  endsequence

  enable_invert_a: assert property (quiet_enable_s |-> ENABLE_OUT == (ENABLE_INPUT ^ ctrl_reg[CTRL_ENABLE_INV]))
    else $error("enable input polarity wrong");
  cw_invert_a: assert property (quiet_cw_s |-> CW_INHIBIT_OUT == (CW_INHIBIT_INPUT ^ ctrl_reg[CTRL_CW_INV]))
    else $error("cw inhibit polarity wrong");
  ccw_invert_a: assert property ($stable({CCW_INHIBIT_INPUT, ctrl_reg[CTRL_CCW_INV]})[*5]
    |-> CCW_INHIBIT_OUT == (CCW_INHIBIT_INPUT ^ ctrl_reg[CTRL_CCW_INV]))
    else $error("ccw inhibit polarity wrong");
  multi_invert_a: assert property ($stable({MULTI_FUNCTION_INPUT, ctrl_reg[CTRL_MULTI_INV]})[*5]
    |-> MULTI_FUNCTION_OUT == (MULTI_FUNCTION_INPUT ^ ctrl_reg[CTRL_MULTI_INV]))
    else $error("multi-function polarity wrong");
  mon_cmd_route_a: assert property ((mon1_sel_reg == 3'h4)
    |=> MONITOR1_OUTPUT == $past(cmd_in_ext[15:4]) + DAC_BIAS)
    else $error("monitor 1 does not follow selection");
  mon_wrap_a: assert property ((mon2_sel_reg == 3'h4 && cmd_in_ext == 16'h8000) |=> MONITOR2_OUTPUT == 12'h000)
    else $error("monitor did not wrap");
  pole_even_a: assert property (MOTOR_POLES[0] == 1'b0 && MOTOR_POLES <= 6'd62)
    else $error("pole count not even or above 62");
  comm_off_a: assert property ((wr_go && sel_poles && AVS_BYTEENABLE[0] && AVS_WRITEDATA[4:0] == 5'h00)
    |=> !COMMUTATION_ENABLE)
    else $error("commutation still on with zero poles");
  prog_lines_a: assert property ((user_switch && sel_reg == SEL_PROGRAMMABLE) |-> active_lines == ppr_reg ##1
    (!prog_sel || active_lines == $past(ppr_reg) || $changed(ppr_reg)))
    else $error("programmable line count not used");
  fixed_switch_a: assert property ((!user_switch && switch_pos == 4'ha) |-> active_lines == 16'd125)
    else $error("switch position line count wrong");
  ccw_clamp_a: assert property (ccw_limit |=> CMD_OUT >= 0)
    else $error("ccw inhibit let a negative command through");
  cw_clamp_a: assert property (cw_limit |=> CMD_OUT <= 0)
    else $error("cw inhibit let a positive command through");
  both_clamp_a: assert property ((ccw_limit && cw_limit) |=> CMD_OUT == 0)
    else $error("both inhibits did not zero the command");
  no_clamp_a: assert property ((!ctrl_reg[CTRL_CCW_INH_EN] && !ctrl_reg[CTRL_CW_INH_EN]) |=> CMD_OUT == $past(CMD_IN))
    else $error("command clamped with inhibits disabled");

endmodule : sico_top

// ---- sico_qdec.sv ----
// sico_qdec: controller model that decodes the emulated quadrature encoder
module sico_qdec (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // emulated encoder
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_z,
  // decoded counts
  output logic [31:0] count,
  output logic [15:0] z_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] prev_reg;
  wire logic [1:0] step = {enc_a, enc_a ^ enc_b} - prev_reg[2:1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 3'h0;
      count <= 32'h0;
      z_cnt <= 16'h0;
    end else begin
      prev_reg <= {enc_a, enc_a ^ enc_b, enc_z};
      count <= count + (step == 2'h1 ? 32'h1 : step == 2'h3 ? 32'hffffffff : 32'h0);
      z_cnt <= z_cnt + 16'(enc_z & ~prev_reg[0]);
    end
  end
endmodule : sico_qdec

// ---- servo_io_conditioning_encoder_emulation_tb.sv ----
// servo_io_conditioning_encoder_emulation_tb: self-checking bench for the servo I/O block
module servo_io_conditioning_encoder_emulation_tb import sico_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, nrst, rd_en, wr_en;
  logic [4:0] addr;
  logic [31:0] wdata, rd, cnt0;
  logic [3:0] pin, sw, a;
  logic [5:0] c;
  logic [15:0] cmd_in, pos, vel_err, vel_fb, cur_fb, z0, off, r;
  logic [15:0] s [8];
  int error_cnt = 0, checked = 0;
  int lt [16] = '{500, 512, 1000, 1024, 2000, 2048, 4096, 5000, 8192, 10000, 125, 128, 16384, 20000, 32768, 2500};
  wire [31:0] rdata, count;
  wire [15:0] cmd_out, z_cnt;
  wire [11:0] mon1, mon2;
  wire [5:0] poles;
  wire [3:0] cond;
  wire wait_req, comm_en, enc_a, enc_b, enc_z;
  sico_top dut (.MCLK(mclk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .ENABLE_INPUT(pin[3]), .CW_INHIBIT_INPUT(pin[2]), .CCW_INHIBIT_INPUT(pin[1]), .MULTI_FUNCTION_INPUT(pin[0]),
    .SETUP_ROTARY_SWITCH(sw), .CMD_IN(cmd_in), .POSITION_FEEDBACK(pos), .VEL_ERR(vel_err), .VEL_FB(vel_fb),
    .CURRENT_FB(cur_fb), .ENABLE_OUT(cond[3]), .CW_INHIBIT_OUT(cond[2]), .CCW_INHIBIT_OUT(cond[1]),
    .MULTI_FUNCTION_OUT(cond[0]), .CMD_OUT(cmd_out), .COMMUTATION_ENABLE(comm_en), .MOTOR_POLES(poles),
    .ENC_A(enc_a), .ENC_B(enc_b), .ENC_Z(enc_z), .MONITOR1_OUTPUT(mon1), .MONITOR2_OUTPUT(mon2));
  sico_qdec ctrl (.clk(mclk), .rst_n(nrst), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .count(count), .z_cnt(z_cnt));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic go(int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : go
  // one Avalon transfer; waitrequest and read data are sampled at the rising edge that completes it
  task automatic bus(bit w, logic [4:0] ad, logic [31:0] d);
    @(posedge mclk);
    addr <= ad;
    wr_en <= w;
    rd_en <= !w;
    wdata <= d;
    do @(posedge mclk); while (wait_req !== 1'b0);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(negedge mclk);
  endtask : bus
  task automatic put_sw(logic [3:0] v);
    @(posedge mclk);
    sw <= v;
    go(8);
  endtask : put_sw
  function automatic logic [2:0] enc(logic [15:0] l);
    logic [33:0] q, z;
    q = pos * l * 4;
    z = 16'(pos - off) * l * 4;
    return {q[17], q[17] ^ q[16], z[33:16] == 0 && l != 0};
  endfunction : enc
  // one revolution in steps of one quadrature count at 1024 lines
  task automatic sweep(logic [31:0] n, logic [15:0] nz);
    @(posedge mclk);
    pos <= off + 16'h10;
    go(3);
    cnt0 = count;
    z0 = z_cnt;
    for (int i = 1; i <= 4096; i++) begin
      @(posedge mclk);
      pos <= off + 16'(i * 16 + 16);
    end
    go(3);
    chk("counts per rev", count - cnt0, n);
    chk("markers", z_cnt - z0, nz);
  endtask : sweep
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    {nrst, rd_en, wr_en, addr, wdata, pin, sw} = '0;
    {cmd_in, pos, vel_err, vel_fb, cur_fb} = '0;
    void'($urandom(15442));
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    bus(0, OFF_PPR, 0);
    chk("ppr reset", rd, 32'h8000);
    bus(0, 5'h1c, 0);
    chk("unmapped", rd, 32'h0);
    for (int i = 0; i < 48; i++) begin
      c = 6'($urandom);
      bus(1, OFF_CTRL, {26'h0, c});
      @(posedge mclk);
      pin <= 4'($urandom);
      cmd_in <= (i % 4 == 0) ? 16'h8000 : (i % 4 == 1) ? 16'h0 : 16'($urandom);
      go(8);
      a = pin ^ {c[0], c[1], c[2], c[3]};
      chk("conditioned", cond, a);
      chk("cmd", cmd_out, ((c[5] & a[2] & !cmd_in[15]) | (c[4] & a[1] & cmd_in[15])) ? 16'h0 : cmd_in);
    end
    for (int n = 0; n < 32; n++) begin
      bus(1, OFF_POLES, n);
      chk("poles", poles, 2 * n);
      chk("commutation", comm_en, n != 0);
    end
    bus(1, OFF_CTRL, 0);
    for (int k = 0; k < 16; k++) begin
      bus(1, OFF_MON_SEL, {21'h0, 3'(7 - k), 5'h0, 3'(k)});
      @(posedge mclk);
      {vel_err, vel_fb, cur_fb, pos} <= {$urandom, $urandom};
      cmd_in <= (k % 8 == 3) ? 16'h8000 : 16'($urandom);
      go(3);
      s = '{vel_err, pos, cur_fb, vel_fb, cmd_in, cmd_in, {pos[11:0], 4'h0}, 16'h0};
      chk("monitor1", mon1, 12'((s[k % 8] >> 4) + 16'h800));
      chk("monitor2", mon2, 12'((s[7 - k % 8] >> 4) + 16'h800));
    end
    r = 16'($urandom);
    bus(1, OFF_PPR, {16'h0, r});
    for (int i = 0; i < 16; i++) begin
      bus(1, OFF_LINE_SEL, i);
      put_sw(4'h0);
      bus(0, OFF_STATUS, 0);
      chk("lines", rd[31:16], (i == 14) ? r : lt[i]);
      put_sw(4'(i));
      bus(0, OFF_STATUS, 0);
      chk("fixed lines", rd[31:16], lt[i]);
    end
    put_sw(4'h0);
    off = 16'($urandom);
    bus(1, OFF_ZOFFSET, {16'h0, off});
    for (int j = 0; j < 24; j++) begin
      if (j == 16) bus(1, OFF_PPR, 0);
      bus(1, OFF_LINE_SEL, j < 8 ? 3 : 14);
      @(posedge mclk);
      pos <= (j % 8 == 0) ? off : (j % 8 == 1) ? off + 16'h10 : (j % 8 == 2) ? 16'h4000 : 16'($urandom);
      go(2);
      chk("encoder", {enc_a, enc_b, enc_z}, enc(j < 8 ? 16'd1024 : j < 16 ? r : 16'h0));
    end
    sweep(0, 0);
    bus(1, OFF_LINE_SEL, 3);
    sweep(4096, 1);
    wrap_up();
  end
endmodule : servo_io_conditioning_encoder_emulation_tb
